//--- logic/slps_regs_map.vh
// register offsets, field positions, reset values and codes for the link parameter/status bank
`ifndef SLPS_REGS_MAP_VH
`define SLPS_REGS_MAP_VH

// register offsets (index on the plain register port)
`define SLPS_ADDR_W             12
`define SLPS_OFF_IDENT          12'h206
`define SLPS_OFF_FRAME_END_CHAR_SELECT          12'h207
`define SLPS_OFF_STATUS         12'h208
`define SLPS_OFF_IRQ_ENABLE     12'h210
`define SLPS_OFF_IRQ_CLEAR      12'h211
`define SLPS_OFF_IRQ_STATUS     12'h212
`define SLPS_OFF_CTRL           12'h213

// reset values
`define SLPS_RST_IDENT          8'h00
`define SLPS_RST_FRAME_END_CHAR_SELECT          2'h0
`define SLPS_RST_BYTE           8'h00
`define SLPS_RST_IDENT_Q        7'h00
`define SLPS_RST_CTRL           2'h0
`define SLPS_RST_IRQ            4'h0
`define SLPS_RST_SYNC           5'h00
`define SLPS_RST_EDGE           2'h0

// field positions inside the data byte
`define SLPS_IDENT_MSB          7
`define SLPS_IDENT_LSB          1
`define SLPS_FRAME_END_CHAR_SELECT_MSB          1
`define SLPS_FRAME_END_CHAR_SELECT_LSB          0
`define SLPS_IRQ_MSB            3
`define SLPS_CTRL_MSB           1

// link status bit positions
`define SLPS_ST_LINK_UP         6
`define SLPS_ST_SYNC            5
`define SLPS_ST_REALIGNED       4
`define SLPS_ST_PHASE_SET       3
`define SLPS_ST_PLL_LOCK        2

// interrupt status / enable / clear bit positions
`define SLPS_IRQ_REALIGNED      0
`define SLPS_IRQ_PHASE_SET      1
`define SLPS_IRQ_LINK_UP        2
`define SLPS_IRQ_PLL_LOST       3
`define SLPS_IRQ_W              4

// control register bit positions
`define SLPS_CTRL_LINK_EN       0
`define SLPS_CTRL_8B10B         1

// frame character selection codes
`define SLPS_FC_K28_7           2'h0
`define SLPS_FC_K28_1           2'h1
`define SLPS_FC_K28_5           2'h2

// 8-bit payloads of the control characters
`define SLPS_K28_7              8'hFC
`define SLPS_K28_1              8'h3C
`define SLPS_K28_5              8'hBC

`endif

//--- logic/slps_regs.v
// serial link parameter and status register bank with event interrupt
`timescale 1ns/1ps
`include "slps_regs_map.vh"

module slps_regs (
	// clock and reset
	input  wire        CLK,
	input  wire        RESET,
	// register port
	input  wire [11:0] ADDR,
	input  wire [7:0]  WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [7:0]  RDATA,
	// link state from the transmitter core (asynchronous to CLK)
	input  wire        LINK_UP,
	input  wire        SYNC_N,
	input  wire        SYSREF_REALIGN,
	input  wire        SYSREF_EVENT,
	input  wire        PLL_LOCKED,
	// parameters handed to the link layer
	output reg  [7:0]  IDENT_LINK_A,
	output reg  [7:0]  IDENT_LINK_B,
	output reg  [7:0]  FRAME_END_CHAR,
	output reg         FRAME_END_CHAR_EN,
	output wire        SERIAL_LINK_ENABLE,
	// interrupt
	output wire        IRQ
);

	// all state lives in this one clock domain; the core levels come in
	// through two flops each before any logic looks at them, and the edge
	// detectors run on the second stage only

	// software state
	reg  [6:0]  ident_q;          // identifier bits 7:1, bit 0 not stored
	reg  [1:0]  frame_end_char_select_q;          // end-of-frame character selection
	reg  [1:0]  ctrl_q;           // link enable and 8b/10b mode
	reg  [3:0]  irq_en_q;         // interrupt enables
	reg  [3:0]  irq_st_q;         // sticky interrupt status
	reg  [3:0]  irq_st_d;         // next interrupt status
	reg         realign_q;        // sticky realigned flag
	reg         phase_set_q;      // sticky multiframe phase flag
	reg         armed_q;          // waiting for first SYSREF after enable
	reg  [7:0]  status_byte;      // assembled link status read value
	reg  [7:0]  rdata_d;          // read value picked by the address
	reg  [7:0]  frame_end_char_select_code;       // control character for the selection

	// two-flop synchronisers for the core inputs
	reg  [4:0]  sync1_q;          // first stage, may go metastable
	reg  [4:0]  sync2_q;          // second stage, the only reader of stage one
	reg  [1:0]  edge_q;           // delayed SYSREF levels for edge detect
	reg         link_prev_q;      // delayed link up level
	reg         pll_prev_q;       // delayed lock level

	// synchronised levels
	wire        link_up_s;        // link up
	wire        sync_n_s;         // sync request, low while asserted
	wire        realign_s;        // SYSREF realign level
	wire        sysref_s;         // SYSREF event level
	wire        pll_s;            // serializer PLL lock

	// one-cycle event strobes
	wire        realign_ev;       // realign level rose
	wire        sysref_ev;        // SYSREF level rose
	wire        phase_ev;         // first SYSREF after enable
	wire        link_up_ev;       // link came up
	wire        pll_lost_ev;      // lock dropped

	// decoded register port strobes
	wire        wr_ident;         // identifier write
	wire        wr_frame_end_char_select;         // frame character write
	wire        wr_ctrl;          // control write
	wire        wr_irq_en;        // interrupt enable write
	wire        wr_status;        // status write, one-to-clear on sticky bits
	wire        wr_irq_clr;       // interrupt clear write
	wire        link_en;          // serial link enable bit
	wire        mode_8b10b;       // 8b/10b line coding selected

	// synchronised level taps, one bit per core input; the order matches
	// the concatenation in the first stage
	assign link_up_s  = sync2_q[0];
	assign sync_n_s   = sync2_q[1];
	assign realign_s  = sync2_q[2];
	assign sysref_s   = sync2_q[3];
	assign pll_s      = sync2_q[4];

	// control bits as the rest of the bank sees them
	assign link_en    = ctrl_q[`SLPS_CTRL_LINK_EN];
	assign mode_8b10b = ctrl_q[`SLPS_CTRL_8B10B];
	assign SERIAL_LINK_ENABLE = link_en;

	// events are rising edges of the synchronised levels, lock loss a falling one; a level
	// already high out of reset gives an event as soon as it has passed the two flops
	assign realign_ev  = realign_s & ~edge_q[0];
	assign sysref_ev   = sysref_s & ~edge_q[1];
	assign phase_ev    = sysref_ev & armed_q & link_en;
	assign link_up_ev  = link_up_s & ~link_prev_q;
	assign pll_lost_ev = ~pll_s & pll_prev_q;

	// one decoder per register; reads and writes share the address
	assign wr_ident   = WR & (ADDR == `SLPS_OFF_IDENT);
	assign wr_frame_end_char_select   = WR & (ADDR == `SLPS_OFF_FRAME_END_CHAR_SELECT);
	assign wr_ctrl    = WR & (ADDR == `SLPS_OFF_CTRL);
	assign wr_irq_en  = WR & (ADDR == `SLPS_OFF_IRQ_ENABLE);
	assign wr_status  = WR & (ADDR == `SLPS_OFF_STATUS);
	assign wr_irq_clr = WR & (ADDR == `SLPS_OFF_IRQ_CLEAR);

	// first synchroniser stage takes the raw core levels
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sync1_q <= `SLPS_RST_SYNC;
		end else begin
			sync1_q <= {PLL_LOCKED, SYSREF_EVENT, SYSREF_REALIGN, SYNC_N, LINK_UP};
		end
	end

	// second stage; nothing else reads the first stage
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sync2_q <= `SLPS_RST_SYNC;
		end else begin
			sync2_q <= sync1_q;
		end
	end

	// delayed copies for edge detection; reset to the idle low level of the
	// core outputs so that no false event follows reset
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			edge_q      <= `SLPS_RST_EDGE;
			link_prev_q <= 1'b0;
			pll_prev_q  <= 1'b0;
		end else begin
			edge_q      <= {sysref_s, realign_s};
			link_prev_q <= link_up_s;
			pll_prev_q  <= pll_s;
		end
	end

	// identifier: bit 0 is never stored, so an odd write drops to the even value
	// below it; the host only rewrites it while the link is off
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ident_q <= `SLPS_RST_IDENT_Q;
		end else if (wr_ident) begin
			ident_q <= WDATA[`SLPS_IDENT_MSB:`SLPS_IDENT_LSB];
		end
	end

	// frame character selection; upper data bits are reserved and dropped;
	// a change while the link runs could cut a frame, so the host waits
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			frame_end_char_select_q <= `SLPS_RST_FRAME_END_CHAR_SELECT;
		end else if (wr_frame_end_char_select) begin
			frame_end_char_select_q <= WDATA[`SLPS_FRAME_END_CHAR_SELECT_MSB:`SLPS_FRAME_END_CHAR_SELECT_LSB];
		end
	end

	// control: link enable and line coding mode; the enable gates the
	// framer, so the parameters above are meant to be set before it
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ctrl_q <= `SLPS_RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_q <= WDATA[`SLPS_CTRL_MSB:`SLPS_CTRL_LINK_EN];
		end
	end

	// interrupt enables, same layout as the interrupt status
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			irq_en_q <= `SLPS_RST_IRQ;
		end else if (wr_irq_en) begin
			irq_en_q <= WDATA[`SLPS_IRQ_MSB:`SLPS_IRQ_REALIGNED];
		end
	end

	// realigned flag: sticky until a one is written to its status bit; an event
	// in the same cycle as the clear wins, so no realignment is ever lost
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			realign_q <= 1'b0;
		end else if (realign_ev) begin
			realign_q <= 1'b1;
		end else if (wr_status && WDATA[`SLPS_ST_REALIGNED]) begin
			realign_q <= 1'b0;
		end
	end

	// multiframe phase flag: set by the first SYSREF after enable, cleared by
	// writing a one; set beats a same-cycle clear
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			phase_set_q <= 1'b0;
		end else if (phase_ev) begin
			phase_set_q <= 1'b1;
		end else if (wr_status && WDATA[`SLPS_ST_PHASE_SET]) begin
			phase_set_q <= 1'b0;
		end
	end

	// arming: held while the link is off, spent by the first SYSREF after
	// enable; later SYSREF edges have no effect here and never set the phase flag
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			armed_q <= 1'b0;
		end else if (!link_en) begin
			armed_q <= 1'b1;
		end else if (sysref_ev) begin
			armed_q <= 1'b0;
		end
	end

	// interrupt status next value: clear first, then events, so set wins;
	// a written one clears its bit, a zero leaves it alone
	always @* begin
		irq_st_d = irq_st_q;
		if (wr_irq_clr) begin
			irq_st_d = irq_st_d & ~WDATA[`SLPS_IRQ_MSB:`SLPS_IRQ_REALIGNED];
		end
		irq_st_d[`SLPS_IRQ_REALIGNED] = irq_st_d[`SLPS_IRQ_REALIGNED] | realign_ev;
		irq_st_d[`SLPS_IRQ_PHASE_SET] = irq_st_d[`SLPS_IRQ_PHASE_SET] | phase_ev;
		irq_st_d[`SLPS_IRQ_LINK_UP]   = irq_st_d[`SLPS_IRQ_LINK_UP] | link_up_ev;
		irq_st_d[`SLPS_IRQ_PLL_LOST]  = irq_st_d[`SLPS_IRQ_PLL_LOST] | pll_lost_ev;
	end

	// interrupt status register, read-only to software
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			irq_st_q <= `SLPS_RST_IRQ;
		end else begin
			irq_st_q <= irq_st_d;
		end
	end

	// level interrupt, high while any enabled status bit is set; it is a
	// gate away from the flops since the host treats it as asynchronous
	assign IRQ = |(irq_st_q & irq_en_q);

	// control character for the current selection; the reserved code falls
	// back to the default so the link never sends an undefined character
	always @* begin
		case (frame_end_char_select_q)
			`SLPS_FC_K28_7: begin
				frame_end_char_select_code = `SLPS_K28_7;
			end
			`SLPS_FC_K28_1: begin
				frame_end_char_select_code = `SLPS_K28_1;
			end
			`SLPS_FC_K28_5: begin
				frame_end_char_select_code = `SLPS_K28_5;
			end
			default: begin
				frame_end_char_select_code = `SLPS_K28_7;                         // reserved code
			end
		endcase
	end

	// link parameters, registered so the link layer sees clean values;
	// a change reaches the link layer one cycle after the register
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			IDENT_LINK_A      <= `SLPS_RST_IDENT;
			IDENT_LINK_B      <= `SLPS_RST_IDENT;
			FRAME_END_CHAR    <= `SLPS_K28_7;
			FRAME_END_CHAR_EN <= 1'b0;
		end else begin
			// link A carries the identifier as programmed
			IDENT_LINK_A <= {ident_q, 1'b0};
			// even base, so adding one only sets bit 0 and never carries
			IDENT_LINK_B <= {ident_q, 1'b1};
			// the character is only a selection; the framer inserts it
			FRAME_END_CHAR <= frame_end_char_select_code;
			// only 8b/10b modes insert the character; 64b/66b ignores it
			FRAME_END_CHAR_EN <= link_en & mode_8b10b;
		end
	end

	// link status as read: live levels and the two sticky flags; reserved
	// bits read zero and writes to them change nothing
	always @* begin
		status_byte = `SLPS_RST_BYTE;
		status_byte[`SLPS_ST_LINK_UP]   = link_up_s;
		status_byte[`SLPS_ST_SYNC]      = sync_n_s;
		status_byte[`SLPS_ST_REALIGNED] = realign_q;
		status_byte[`SLPS_ST_PHASE_SET] = phase_set_q;
		status_byte[`SLPS_ST_PLL_LOCK]  = pll_s;
	end

	// read value by address; unmapped offsets and the clear register read
	// zero, since the clear register holds no state of its own
	always @* begin
		case (ADDR)
			`SLPS_OFF_IDENT: begin
				rdata_d = {ident_q, 1'b0};
			end
			`SLPS_OFF_FRAME_END_CHAR_SELECT: begin
				rdata_d = {6'h00, frame_end_char_select_q};
			end
			`SLPS_OFF_STATUS: begin
				rdata_d = status_byte;
			end
			`SLPS_OFF_IRQ_ENABLE: begin
				rdata_d = {4'h0, irq_en_q};
			end
			`SLPS_OFF_IRQ_STATUS: begin
				rdata_d = {4'h0, irq_st_q};
			end
			`SLPS_OFF_CTRL: begin
				rdata_d = {6'h00, ctrl_q};
			end
			default: begin
				rdata_d = `SLPS_RST_BYTE;                         // unmapped and clear reg
			end
		endcase
	end

	// read data stands only in the cycle after the strobe and is zero
	// otherwise, so a stale value can never be mistaken for an answer
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			RDATA <= `SLPS_RST_BYTE;
		end else if (RD) begin
			RDATA <= rdata_d;
		end else begin
			RDATA <= `SLPS_RST_BYTE;
		end
	end

endmodule // slps_regs

//--- test/slps_regs_properties.sv
// assertion checker for the link parameter and status bank
`timescale 1ns/1ps
module slps_regs_properties (
	// clock and reset
	input wire        CLK,
	input wire        RESET,
	// register port
	input wire [11:0] ADDR,
	input wire [7:0]  WDATA,
	input wire        WR,
	input wire        RD,
	input wire [7:0]  RDATA,
	// link levels and bank outputs
	input wire        LINK_UP,
	input wire        SYNC_N,
	input wire        PLL_LOCKED,
	input wire [7:0]  IDENT_LINK_A,
	input wire [7:0]  IDENT_LINK_B,
	input wire [7:0]  FRAME_END_CHAR,
	input wire        FRAME_END_CHAR_EN,
	input wire        SERIAL_LINK_ENABLE,
	input wire        IRQ
);
	wire [2:0] lvl = {LINK_UP, SYNC_N, PLL_LOCKED}; // levels mirrored in status
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// code sent for each selection; reserved falls back to the default
	function [7:0] fc(input [1:0] s);
		fc = (s == 2'h1) ? 8'h3C : (s == 2'h2) ? 8'hBC : 8'hFC;
	endfunction
	property p_ident;
		WR && ADDR == 12'h206 |-> ##2 IDENT_LINK_A == {$past(WDATA[7:1], 2), 1'b0}
			&& IDENT_LINK_B == {$past(WDATA[7:1], 2), 1'b1};
	endproperty
	a_ident: assert property (p_ident) else $error("link identifiers wrong");
	property p_id_lsb;
		RD && ADDR == 12'h206 |=> !RDATA[0];
	endproperty
	a_id_lsb: assert property (p_id_lsb) else $error("identifier bit 0 not zero");
	property p_idle;
		!RD |=> RDATA == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	property p_frame_end_char_select;
		WR && ADDR == 12'h207 |-> ##2 FRAME_END_CHAR == fc($past(WDATA[1:0], 2));
	endproperty
	a_frame_end_char_select: assert property (p_frame_end_char_select) else $error("frame end code wrong");
	property p_fce;
		FRAME_END_CHAR_EN |-> $past(SERIAL_LINK_ENABLE);
	endproperty
	a_fce: assert property (p_fce) else $error("frame char on while disabled");
	property p_stat;
		RD && ADDR == 12'h208 && $past(lvl, 1) == lvl && $past(lvl, 2) == lvl
			&& $past(lvl, 3) == lvl && $past(lvl, 4) == lvl && !$past(RESET, 4)
			|=> {RDATA[7:5], RDATA[2:0]} == {1'b0, $past(lvl[2:1]), $past(lvl[0]), 2'b00};
	endproperty
	a_stat: assert property (p_stat) else $error("status levels wrong");
	property p_hold;
		IRQ && !WR |=> IRQ;
	endproperty
	a_hold: assert property (p_hold) else $error("interrupt dropped by itself");
	property p_ena;
		$changed(SERIAL_LINK_ENABLE) |-> $past(WR && ADDR == 12'h213);
	endproperty
	a_ena: assert property (p_ena) else $error("enable moved without write");
endmodule // slps_regs_properties

bind slps_regs slps_regs_properties chk_u (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINK_UP(LINK_UP), .SYNC_N(SYNC_N),
	.PLL_LOCKED(PLL_LOCKED), .IDENT_LINK_A(IDENT_LINK_A), .IDENT_LINK_B(IDENT_LINK_B),
	.FRAME_END_CHAR(FRAME_END_CHAR), .FRAME_END_CHAR_EN(FRAME_END_CHAR_EN),
	.SERIAL_LINK_ENABLE(SERIAL_LINK_ENABLE), .IRQ(IRQ));

//--- test/slps_link_model.sv
// model of the serializer core and far receiver driving link levels
`timescale 1ns/1ps
module slps_link_model (
	// clock
	input wire       CLK,
	// control
	input wire       link_en,
	input wire [3:0] lag,
	// link levels
	output reg       pll_locked = 1'b0,
	output reg       sync_n = 1'b0,
	output reg       link_up = 1'b0,
	output reg       sysref = 1'b0
);
	reg [7:0] cnt_q = 8'h00; // cycles since enable, saturating
	// stages follow enable after a chosen lag, so slow and prompt links both occur
	always @(posedge CLK) begin
		cnt_q <= link_en ? cnt_q + {7'h00, cnt_q != 8'hFF} : 8'h00;
		pll_locked <= link_en && cnt_q > {4'h0, lag};
		sync_n <= link_en && cnt_q > {3'h0, lag, 1'b0}; // receiver holds sync until lock
		link_up <= link_en && cnt_q > {3'h0, lag, 1'b0} + 8'h04;
		sysref <= cnt_q >= 8'h20 && cnt_q < 8'h24; // four cycles, wider than sync needs
	end
endmodule // slps_link_model

//--- test/tb.sv
// self-checking bench for the link parameter and status bank
`timescale 1ns/1ps
module tb;
	reg        CLK = 1'b0;
	reg        RESET = 1'b1;
	reg [11:0] ADDR = 12'h000;
	reg [7:0]  WDATA = 8'h00;
	reg        WR = 1'b0;
	reg        RD = 1'b0;
	reg        realign = 1'b0; // realign pulse
	reg [3:0]  lag = 4'h3;     // model delay
	reg [7:0]  v;
	wire [7:0] RDATA, id_a, id_b, frame_end_char_select;
	wire       up, sync_n, sysref, lock, fce, en, IRQ;
	integer    n_fail = 0, samples_checked = 0, seed = 45, i, r;
	always #2 CLK = ~CLK;
	slps_regs dut_u (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .LINK_UP(up), .SYNC_N(sync_n), .SYSREF_REALIGN(realign),
		.SYSREF_EVENT(sysref), .PLL_LOCKED(lock), .IDENT_LINK_A(id_a), .IDENT_LINK_B(id_b),
		.FRAME_END_CHAR(frame_end_char_select), .FRAME_END_CHAR_EN(fce), .SERIAL_LINK_ENABLE(en), .IRQ(IRQ));
	slps_link_model far_u (.CLK(CLK), .link_en(en), .lag(lag), .pll_locked(lock),
		.sync_n(sync_n), .link_up(up), .sysref(sysref));
	function [7:0] fc_exp(input [1:0] s);
		fc_exp = (s == 2'h1) ? 8'h3C : (s == 2'h2) ? 8'hBC : 8'hFC;
	endfunction
	task conclude;
		begin
			if (n_fail == 0 && samples_checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task chk(input [8*6:1] n, input [7:0] s, input [7:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (s !== e) begin
				n_fail = n_fail + 1;
				$display("[FAIL] %0s expected %h seen %h", n, e, s);
			end
		end
	endtask
	task wr(input [11:0] a, input [7:0] d);
		begin
			@(posedge CLK);
			ADDR <= a;
			WDATA <= d;
			WR <= 1'b1;
			@(posedge CLK);
			WR <= 1'b0;
		end
	endtask
	// read data stands only in the cycle after the strobe
	task rd(input [11:0] a, input [7:0] e);
		begin
			@(posedge CLK);
			ADDR <= a;
			RD <= 1'b1;
			@(posedge CLK);
			RD <= 1'b0;
			@(negedge CLK);
			chk("rdata", RDATA, e);
		end
	endtask
	// bounded wait for the interrupt
	task wait_irq;
		integer k;
		begin
			for (k = 0; k < 200 && IRQ !== 1'b1; k = k + 1)
				@(posedge CLK);
			if (k == 200) begin
				n_fail = n_fail + 1;
				$display("[FAIL] irq expected 1 seen %b", IRQ);
				conclude;
			end
		end
	endtask
	initial begin
		repeat (6) @(posedge CLK);
		RESET <= 1'b0;
		rd(12'h206, 8'h00);
		rd(12'h207, 8'h00);
		rd(12'h208, 8'h00);
		rd(12'h211, 8'h00);
		rd(12'h3FF, 8'h00);
		// identifiers 8'hFF, 8'h01, then random ones, and every selection code, link still off
		for (i = 0; i < 10; i = i + 1) begin
			r = $random(seed);
			v = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : r[7:0];
			wr(12'h206, v);
			rd(12'h206, {v[7:1], 1'b0});
			chk("id_a", id_a, {v[7:1], 1'b0});
			chk("id_b", id_b, {v[7:1], 1'b1});
			wr(12'h207, {r[15:10], i[1:0]});
			rd(12'h207, {6'h00, i[1:0]});
			chk("frame_end_char_select", frame_end_char_select, fc_exp(i[1:0]));
		end
		// bring the link up at a random pace
		wr(12'h210, 8'h0F);
		rd(12'h210, 8'h0F);
		lag <= r[19:16];
		wr(12'h213, 8'h03);
		rd(12'h213, 8'h03);
		chk("en", {7'h00, en}, 8'h01);
		wait_irq;
		repeat (48) @(posedge CLK);
		rd(12'h208, 8'h6C);
		chk("fce", {7'h00, fce}, 8'h01);
		rd(12'h212, 8'h06);
		wr(12'h208, 8'h08);
		rd(12'h208, 8'h64);
		wr(12'h211, 8'h0F);
		rd(12'h212, 8'h00);
		chk("irq", {7'h00, IRQ}, 8'h00);
		// realign with its interrupt masked, then unmasked and cleared
		wr(12'h210, 8'h0E);
		@(posedge CLK);
		realign <= 1'b1;
		repeat (4) @(posedge CLK);
		realign <= 1'b0;
		repeat (8) @(posedge CLK);
		rd(12'h208, 8'h74);
		chk("irq", {7'h00, IRQ}, 8'h00);
		wr(12'h210, 8'h0F);
		rd(12'h212, 8'h01);
		chk("irq", {7'h00, IRQ}, 8'h01);
		wr(12'h208, 8'h10);
		rd(12'h208, 8'h64);
		wr(12'h211, 8'h01);
		rd(12'h212, 8'h00);
		// disable: lock loss raises its event, levels fall
		wr(12'h213, 8'h02);
		repeat (8) @(posedge CLK);
		rd(12'h208, 8'h00);
		chk("fce", {7'h00, fce}, 8'h00);
		rd(12'h212, 8'h08);
		// link on with 64b/66b coding: the character stays switched off
		wr(12'h213, 8'h01);
		rd(12'h213, 8'h01);
		chk("fce", {7'h00, fce}, 8'h00);
		conclude;
	end
endmodule // tb
